/* File: pkg/msd_pkg.sv */
// Package: constants and types of the motion stop/start detector
package msd_pkg;
   // ----------------------------------------------------------------
   // Conversion and timing
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 10;
   localparam int DATA_W = 12;
   localparam logic [9:0] ZERO_G_CODE = 10'h1f4;
   localparam int SAMPLE_PERIOD_MS = 4;
   localparam int STOP_TIME_MS = 120;
   localparam int TURN_TIME_MS = 20;
   localparam logic [7:0] STOP_SAMPLES =
      8'((STOP_TIME_MS + SAMPLE_PERIOD_MS - 1) / SAMPLE_PERIOD_MS);
   localparam logic [7:0] TURN_SAMPLES =
      8'((TURN_TIME_MS + SAMPLE_PERIOD_MS - 1) / SAMPLE_PERIOD_MS);
   // ----------------------------------------------------------------
   // Threshold reset values and accumulator width
   // ----------------------------------------------------------------
   localparam logic [9:0] QUIET_THR_RST = 10'h014;
   localparam logic [9:0] MOVE_THR_RST = 10'h01e;
   localparam logic [9:0] TURN_THR_RST = 10'h005;
   localparam int SUM_W = 20;
   // ----------------------------------------------------------------
   // Top level states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MSD_WAIT_STOP = 3'b001,
      MSD_STOPPED = 3'b010,
      MSD_MOVING = 3'b100
   } msd_state_type;
endpackage : msd_pkg

/* File: hw/msd_axis.sv */
// Per-axis quiet detection, baseline and first wave maximum tracking
`timescale 1ns/1ps
module msd_axis
   import msd_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sample_i,
   input wire logic [SAMPLE_W-1:0] raw_i,
   input wire logic [1:0] mode_i,
   input wire logic capture_i,
   input wire logic [9:0] quiet_thr_i,
   input wire logic [9:0] move_thr_i,
   input wire logic [9:0] turn_thr_i,
   input wire logic [7:0] turn_len_i,
   output logic quiet_o,
   output logic moved_o,
   output logic dir_o,
   output logic peak_done_o,
   output logic signed [DATA_W-1:0] value_o,
   output logic signed [DATA_W-1:0] base_o,
   output logic signed [DATA_W-1:0] peak_o
);
   typedef struct packed {
      logic signed [DATA_W-1:0] prev;
      logic signed [DATA_W-1:0] value;
      logic signed [DATA_W-1:0] base;
      logic signed [SUM_W-1:0] sum;
      logic [7:0] cnt;
      logic dir;
      logic falling;
      logic done;
      logic signed [DATA_W-1:0] peak;
      logic [7:0] tcnt;
   } msd_ax_type;
   msd_ax_type s_r, s_nxt;
   logic signed [DATA_W-1:0] cur, diff, dev, sdev, speak, gap;
   logic [DATA_W-1:0] adiff, adev;

   assign cur = DATA_W'($signed({2'b00, raw_i}) -
      $signed({2'b00, ZERO_G_CODE})); // [R1]
   assign diff = cur - s_r.prev;
   assign adiff = diff[DATA_W-1] ? DATA_W'(-diff) : diff;
   assign dev = cur - s_r.base;
   assign adev = dev[DATA_W-1] ? DATA_W'(-dev) : dev;
   // Deviation mirrored so growth is always positive in the move direction
   assign sdev = s_r.dir ? DATA_W'(-dev) : dev;
   assign speak = s_r.dir ? DATA_W'(-s_r.peak) : s_r.peak;
   assign gap = speak - sdev;
   assign quiet_o = adiff <= {2'b00, quiet_thr_i}; // [R3]
   assign moved_o = adev >= {2'b00, move_thr_i}; // [R6]

   always_comb begin
      s_nxt = s_r;
      // Capture comes in the cycle after the stop sample, with or without a sample
      if (capture_i) begin
         // Average over the quiet run, rounded toward zero
         s_nxt.base = DATA_W'(s_r.sum / $signed({12'h000, s_r.cnt})); // [R5]
      end
      if (sample_i) begin
         s_nxt.prev = cur;
         s_nxt.value = cur;
         case (mode_i)
            2'd0: begin
               if (quiet_o) begin
                  s_nxt.sum = s_r.sum + SUM_W'(cur); // [R5]
                  s_nxt.cnt = s_r.cnt + 8'h01;
               end else begin
                  s_nxt.sum = '0; // [R4]
                  s_nxt.cnt = 8'h00;
               end
            end
            2'd1: begin
               s_nxt.dir = dev[DATA_W-1]; // [R7]
               s_nxt.peak = dev; // [R8]
               s_nxt.falling = 1'b0;
               s_nxt.done = 1'b0;
               s_nxt.tcnt = 8'h00;
               s_nxt.sum = '0;
               s_nxt.cnt = 8'h00;
            end
            2'd2: begin
               if (!s_r.done) begin
                  if (sdev > speak) begin
                     s_nxt.peak = dev; // [R8]
                     s_nxt.falling = 1'b0;
                     s_nxt.tcnt = 8'h00;
                  end else if (sdev < speak) begin
                     s_nxt.falling = 1'b1;
                     s_nxt.tcnt = s_r.tcnt + 8'h01;
                     if (s_r.tcnt + 8'h01 >= turn_len_i &&
                         gap >= $signed({2'b00, turn_thr_i})) begin
                        s_nxt.done = 1'b1; // [R9]
                     end
                  end else begin
                     s_nxt.tcnt = 8'h00;
                  end
               end
            end
            default: begin
               s_nxt.sum = '0;
               s_nxt.cnt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dir_o = s_r.dir;
   assign peak_done_o = s_r.done;
   assign value_o = s_r.value;
   assign base_o = s_r.base;
   assign peak_o = s_r.peak;
endmodule : msd_axis

/* File: hw/msd_top.sv */
// Motion stop/start detector: three axes, stop, move start, first peak
//
// Summary of operation
// R1: Each axis subtracts zero-g code 500; one g is about 137 counts.
// R2: Converter delivers one X/Y/Z triple every 4 ms; one triple per period.
// R3: Axis quiet when change from previous sample is at most threshold (20).
// R4: Stopped after all axes quiet for 120 ms; noisy sample restarts count.
// R5: On stop, each axis baseline is average of quiet-interval samples.
// R6: While stopped, move start when axis deviates at least 30 from base.
// R7: Direction per axis from deviation sign: positive rear/left/down.
// R8: After move start, track first wave maximum of deviation.
// R9: Peak fixed when wave falls below it 20 ms and by at least 5.
// R10: Quiet/move thresholds, stop duration programmable; reset defaults; in samples.
// R11: Move start only while stopped; reset or end of tracking return to stop detection.
`timescale 1ns/1ps
module msd_top
   import msd_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sample_valid_i,
   input wire logic [SAMPLE_W-1:0] x_raw_i,
   input wire logic [SAMPLE_W-1:0] y_raw_i,
   input wire logic [SAMPLE_W-1:0] z_raw_i,
   input wire logic cfg_we_i,
   input wire logic [9:0] quiet_thr_i,
   input wire logic [9:0] move_thr_i,
   input wire logic [7:0] stop_len_i,
   input wire logic track_end_i,
   output logic stopped_o,
   output logic moving_o,
   output logic move_start_o,
   output logic [2:0] dir_o,
   output logic peak_done_o,
   output logic [3*DATA_W-1:0] value_o,
   output logic [3*DATA_W-1:0] base_o,
   output logic [3*DATA_W-1:0] peak_o,
   output logic [9:0] quiet_thr_o,
   output logic [9:0] move_thr_o,
   output logic [7:0] stop_len_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      msd_state_type st;
      logic [9:0] quiet_thr;
      logic [9:0] move_thr;
      logic [7:0] stop_len;
      logic [7:0] qcnt;
      logic start;
   } msd_top_type;
   msd_top_type s_r, s_nxt;
   logic [2:0] quiet, moved, dir, pdone;
   logic [1:0] mode;
   logic capture, all_quiet;
   logic [SAMPLE_W-1:0] raw [3];

   assign raw[0] = x_raw_i;
   assign raw[1] = y_raw_i;
   assign raw[2] = z_raw_i;
   assign all_quiet = &quiet;

   // ----------------------------------------------------------------
   // Axis datapaths
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_axis
      msd_axis u_axis (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .sample_i(sample_valid_i), // [R2]
         .raw_i(raw[g]),
         .mode_i(mode),
         .capture_i(capture),
         .quiet_thr_i(s_r.quiet_thr),
         .move_thr_i(s_r.move_thr),
         .turn_thr_i(TURN_THR_RST),
         .turn_len_i(TURN_SAMPLES),
         .quiet_o(quiet[g]),
         .moved_o(moved[g]),
         .dir_o(dir[g]),
         .peak_done_o(pdone[g]),
         .value_o(value_o[g*DATA_W +: DATA_W]),
         .base_o(base_o[g*DATA_W +: DATA_W]),
         .peak_o(peak_o[g*DATA_W +: DATA_W])
      );
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      mode = 2'd3;
      capture = 1'b0;
      if (cfg_we_i) begin
         s_nxt.quiet_thr = quiet_thr_i; // [R10]
         s_nxt.move_thr = move_thr_i;
         s_nxt.stop_len = (stop_len_i == 8'h00) ? 8'h01 : stop_len_i;
      end
      case (s_r.st)
         MSD_WAIT_STOP: begin
            mode = 2'd0;
            if (sample_valid_i) begin
               if (all_quiet) begin
                  s_nxt.qcnt = s_r.qcnt + 8'h01; // [R4]
                  if (s_r.qcnt + 8'h01 >= s_r.stop_len) begin
                     s_nxt.st = MSD_STOPPED;
                     s_nxt.qcnt = 8'h00;
                  end
               end else begin
                  s_nxt.qcnt = 8'h00; // [R4]
               end
            end
         end
         MSD_STOPPED: begin
            // Baseline taken from sums accumulated up to the stop sample
            mode = 2'd0;
            capture = s_r.qcnt == 8'h00;
            s_nxt.qcnt = 8'h01;
            if (sample_valid_i && capture) begin
               mode = 2'd3;
            end else if (sample_valid_i && |moved) begin
               mode = 2'd1; // [R6] [R11]
               s_nxt.st = MSD_MOVING;
               s_nxt.start = 1'b1;
               s_nxt.qcnt = 8'h00;
            end else begin
               mode = 2'd3;
            end
         end
         MSD_MOVING: begin
            mode = 2'd2; // [R8]
            if (track_end_i) begin
               s_nxt.st = MSD_WAIT_STOP; // [R11]
               s_nxt.qcnt = 8'h00;
            end
         end
         default: begin
            s_nxt.st = MSD_WAIT_STOP;
            s_nxt.qcnt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r.st <= MSD_WAIT_STOP; // [R11]
         s_r.quiet_thr <= QUIET_THR_RST; // [R10]
         s_r.move_thr <= MOVE_THR_RST;
         s_r.stop_len <= STOP_SAMPLES;
         s_r.qcnt <= 8'h00;
         s_r.start <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign stopped_o = s_r.st == MSD_STOPPED;
   assign moving_o = s_r.st == MSD_MOVING;
   assign move_start_o = s_r.start;
   assign dir_o = dir; // [R7]
   assign peak_done_o = &pdone | (|pdone & moving_o);
   assign quiet_thr_o = s_r.quiet_thr;
   assign move_thr_o = s_r.move_thr;
   assign stop_len_o = s_r.stop_len;
endmodule : msd_top

/* File: sim/msd_adc_model.sv */
// Converter model: one X/Y/Z triple per sample period
`timescale 1ns/1ps
module msd_adc_model #(
   parameter int PERIOD = 8
) (
   input wire logic clk_i,
   input wire logic [29:0] code_i,
   output logic valid_o,
   output logic [29:0] raw_o
);
   int cnt = 0;
   logic [29:0] last = 30'h0;
   initial valid_o = 1'b0;
   always @(posedge clk_i) begin
      #1;
      valid_o = 1'b0;
      cnt = cnt + 1;
      if (cnt == PERIOD) begin
         cnt = 0;
         valid_o = 1'b1;
         last = code_i;
      end
   end
   // Lines carry the inverted last triple outside the valid cycle
   assign raw_o = valid_o ? last : ~last;
endmodule : msd_adc_model

/* File: sim/msd_checker.sv */
// Checker: port-level properties of the detector
`timescale 1ns/1ps
module msd_checker
   import msd_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sample_valid_i,
   input wire logic [SAMPLE_W-1:0] x_raw_i,
   input wire logic [SAMPLE_W-1:0] z_raw_i,
   input wire logic cfg_we_i,
   input wire logic [9:0] quiet_thr_i,
   input wire logic [9:0] move_thr_i,
   input wire logic track_end_i,
   input wire logic stopped_o,
   input wire logic moving_o,
   input wire logic move_start_o,
   input wire logic [2:0] dir_o,
   input wire logic [3*DATA_W-1:0] value_o,
   input wire logic [3*DATA_W-1:0] base_o,
   input wire logic [9:0] quiet_thr_o,
   input wire logic [9:0] move_thr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   value_x_a: assert property (
      sample_valid_i |=> value_o[11:0] == {2'h0, $past(x_raw_i)} - 12'h1f4)
      else $error("x value not offset corrected");
   value_z_a: assert property (
      sample_valid_i |=> value_o[35:24] == {2'h0, $past(z_raw_i)} - 12'h1f4)
      else $error("z value not offset corrected");
   stop_cause_a: assert property (
      $rose(stopped_o) |-> $past(sample_valid_i) && !$past(moving_o))
      else $error("stop without a sample");
   move_cause_a: assert property (
      move_start_o |-> $past(stopped_o) && $past(sample_valid_i))
      else $error("move start outside stopped state");
   move_pulse_a: assert property (
      move_start_o |-> moving_o && !stopped_o ##1 !move_start_o)
      else $error("move start pulse malformed");
   dir_sign_a: assert property (
      move_start_o |->
         dir_o[1] == ($signed(value_o[23:12]) < $signed(base_o[23:12])))
      else $error("y direction wrong");
   track_end_a: assert property (
      moving_o && track_end_i |=> !moving_o && !stopped_o)
      else $error("track end ignored");
   cfg_load_a: assert property (
      cfg_we_i |=> quiet_thr_o == $past(quiet_thr_i)
         && move_thr_o == $past(move_thr_i))
      else $error("settings not loaded");
   stop_leave_a: assert property (
      $fell(stopped_o) |-> moving_o)
      else $error("stopped left without movement");
endmodule : msd_checker
bind msd_top msd_checker u_msd_checker (.clk_i(clk_i), .resetn_i(resetn_i),
   .sample_valid_i(sample_valid_i), .x_raw_i(x_raw_i), .z_raw_i(z_raw_i),
   .cfg_we_i(cfg_we_i), .quiet_thr_i(quiet_thr_i), .move_thr_i(move_thr_i),
   .track_end_i(track_end_i), .stopped_o(stopped_o), .moving_o(moving_o),
   .move_start_o(move_start_o), .dir_o(dir_o), .value_o(value_o),
   .base_o(base_o), .quiet_thr_o(quiet_thr_o), .move_thr_o(move_thr_o));

/* File: sim/tb_motion_stop_start_detector.sv */
// Testbench: stop detection, move start, first peak, settings
`timescale 1ns/1ps
module tb_motion_stop_start_detector;
   import msd_pkg::*;
   logic clk, resetn, cfg_we, track_end, valid;
   logic stopped, moving, mstart, pdone;
   logic [9:0] qthr, mthr, qthr_o, mthr_o;
   logic [7:0] slen, slen_o;
   logic [29:0] code, raw;
   logic [2:0] dir;
   logic [35:0] value, base, peak;
   int n_errors = 0;
   int comparisons = 0;
   msd_adc_model u_msd_adc_model (.clk_i(clk), .code_i(code),
      .valid_o(valid), .raw_o(raw));
   msd_top u_msd_top (.clk_i(clk), .resetn_i(resetn), .sample_valid_i(valid),
      .x_raw_i(raw[9:0]), .y_raw_i(raw[19:10]), .z_raw_i(raw[29:20]),
      .cfg_we_i(cfg_we), .quiet_thr_i(qthr), .move_thr_i(mthr),
      .stop_len_i(slen), .track_end_i(track_end), .stopped_o(stopped),
      .moving_o(moving), .move_start_o(mstart), .dir_o(dir),
      .peak_done_o(pdone), .value_o(value), .base_o(base), .peak_o(peak),
      .quiet_thr_o(qthr_o), .move_thr_o(mthr_o), .stop_len_o(slen_o));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic print_verdict;
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Present a triple and return just after the edge that takes it
   task automatic smp(input logic [9:0] x, input logic [9:0] y,
         input logic [9:0] z);
      int i;
      code = {z, y, x};
      i = 0;
      // Valid is looked at only on edges, where the design samples it
      do begin
         @(posedge clk);
         i++;
      end while (valid !== 1'b1 && i < 20);
      if (valid !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t no sample", $time);
         print_verdict();
      end
      #1;
   endtask : smp
   task automatic t_cfg(input logic [9:0] q, input logic [9:0] m,
         input logic [7:0] len);
      qthr = q;
      mthr = m;
      slen = len;
      cfg_we = 1'b1;
      @(posedge clk);
      #1;
      cfg_we = 1'b0;
   endtask : t_cfg
   task automatic t_stop;
      logic [9:0] xs [6] = '{10'h258, 10'h26d, 10'h259, 10'h26d, 10'h259,
         10'h26d};
      for (int i = 0; i < 6; i++) begin
         smp(xs[i], 10'h1c2, 10'h27d);
         chk(stopped, i == 5);
      end
      smp(10'h259, 10'h1c2, 10'h27d);
      chk(base, {12'h089, 12'hfce, 12'h06f});
   endtask : t_stop
   task automatic t_move;
      smp(10'h280, 10'h1c2, 10'h27d);
      chk(moving, 1'b0);
      smp(10'h281, 10'h19a, 10'h27d);
      chk({mstart, moving, stopped}, 3'b110);
      chk(dir, 3'b010);
   endtask : t_move
   task automatic t_peak;
      smp(10'h295, 10'h19a, 10'h27d);
      chk(peak[11:0], 12'h032);
      smp(10'h29f, 10'h19a, 10'h27d);
      for (int i = 0; i < 5; i++) begin
         smp(10'(10'h299 - i), 10'h19a, 10'h27d);
         chk(pdone, i == 4);
      end
      chk(peak[11:0], 12'h03c);
   endtask : t_peak
   task automatic t_end;
      track_end = 1'b1;
      @(posedge clk);
      #1;
      track_end = 1'b0;
      chk({moving, stopped}, 2'b00);
      resetn = 1'b0;
      @(posedge clk);
      #1;
      resetn = 1'b1;
      chk({qthr_o, mthr_o, slen_o}, {10'h014, 10'h01e, 8'h1e});
   endtask : t_end
   initial begin
      resetn = 1'b0;
      cfg_we = 1'b0;
      track_end = 1'b0;
      qthr = 10'h014;
      mthr = 10'h01e;
      slen = 8'h1e;
      code = {3{10'h1f4}};
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk({qthr_o, mthr_o, slen_o, stopped},
         {10'h014, 10'h01e, 8'h1e, 1'b0});
      t_cfg(10'h155, 10'h2aa, 8'h00);
      chk({qthr_o, mthr_o, slen_o}, {10'h155, 10'h2aa, 8'h01});
      t_cfg(10'h014, 10'h01e, 8'h04);
      chk({qthr_o, mthr_o, slen_o}, {10'h014, 10'h01e, 8'h04});
      t_stop();
      t_move();
      t_peak();
      t_end();
      print_verdict();
   end
endmodule : tb_motion_stop_start_detector
